// *** dv/lp_cmd_sva.sv ***
// ----------------------------------------
// Interface checks between the two ends
// ----------------------------------------
module lp_cmd_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic ctl_oe_n,
  input wire logic dev_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic wr_pins;
  logic rd_pins;
  assign wr_pins = !cs_n && ras_n && !cas_n && !we_n;
  assign rd_pins = !cs_n && ras_n && !cas_n && we_n;
  rst_vals_a: assert property ($fell(rst) |-> !cke && cs_n && ctl_oe_n && dev_oe_n)
    else $error("pins not idle after reset");
  desel_next_a: assert property (!cs_n |=> cs_n)
    else $error("command held past one cycle");
  no_contend_a: assert property (!(!ctl_oe_n && !dev_oe_n))
    else $error("both ends drive data");
  wr_drive_a: assert property (wr_pins |-> ##[1:2] !ctl_oe_n)
    else $error("write data not driven");
  drive_cause_a: assert property ($fell(ctl_oe_n) |-> $past(wr_pins) || $past(wr_pins, 2))
    else $error("data driven without write");
  rd_answer_a: assert property (rd_pins && cke |-> ##[3:12] !dev_oe_n)
    else $error("read not answered");
  dev_gate_a: assert property ($fell(dev_oe_n) |-> cke)
    else $error("device drives while gated");
  dev_release_a: assert property ($fell(dev_oe_n) |-> ##[1:40] dev_oe_n)
    else $error("device holds data bus");
endmodule

// *** dv/tb_lpddr_command_input_control.sv ***
module tb_lpddr_command_input_control;
  timeunit 1ns;
  timeprecision 1ps;
  import lp_cmd_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  cmd_t req_cmd = CMD_NOP;
  logic [1:0] req_bank = 2'h0;
  logic [13:0] req_addr = 14'h0000;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_wmask = 4'h0;
  logic req_wlast = 1'b1;
  logic gate_req = 1'b0;
  logic req_ready, rd_valid, cmd_seen;
  logic [31:0] rd_data;
  logic [3:0] bank_open;
  pwr_t pwr_state;
  logic [13:0] mr [4];
  int fail_count = 0;
  int n_tests = 0;
  int seen_n = 0;
  int exp_seen = 0;
  logic [3:0] exp_open = 4'h0;
  logic [13:0] exp_mr [4];
  logic [31:0] rd_q [$];
  always #5 clock = ~clock;
  lp_cmd_if link();
  lp_cmd_ctl i_lp_cmd_ctl (.clock(clock), .rst(rst), .link(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_wmask(req_wmask), .req_wlast(req_wlast), .gate_req(gate_req),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid));
  lp_cmd_dev i_lp_cmd_dev (.clock(clock), .rst(rst), .link(link), .bank_open(bank_open),
    .pwr_state(pwr_state), .mode_reg0(mr[0]), .mode_reg1(mr[1]), .mode_reg2(mr[2]),
    .mode_reg3(mr[3]), .cmd_seen(cmd_seen));
  lp_cmd_sva i_lp_cmd_sva (.clock(clock), .rst(rst), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ctl_oe_n(link.ctl_oe_n),
    .dev_oe_n(link.dev_oe_n));
  always @(posedge clock) begin
    if (cmd_seen === 1'b1) seen_n++;
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
  end
  // ----------------------------------------
  // Compare and drive tasks
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_state(input logic [13:0] got, input logic [13:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t state %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input cmd_t c, input logic [1:0] b, input logic [13:0] a);
    int k;
    k = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    @(negedge clock);
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    @(posedge clock);
    req_valid <= 1'b0;
    repeat (12) @(posedge clock);
    if (c != CMD_DESEL) exp_seen++;
    case (c)
      CMD_LMR: exp_mr[b] = a;
      CMD_ACT: exp_open[b] = 1'b1;
      CMD_PRE: exp_open = a[10] ? 4'h0 : exp_open & ~(4'h1 << b);
      CMD_WR, CMD_RD: if (a[10]) exp_open[b] = 1'b0;
      default: ;
    endcase
    chk_state(14'(seen_n), 14'(exp_seen));
    chk_state({10'h0, bank_open}, {10'h0, exp_open});
  endtask
  task automatic pd(input pwr_t p);
    @(posedge clock);
    gate_req <= 1'b0;
    repeat (10) @(posedge clock);
    chk_state({12'h0, pwr_state}, {12'h0, p});
    gate_req <= 1'b1;
    repeat (10) @(posedge clock);
    chk_state({12'h0, pwr_state}, {12'h0, PWR_RUN});
  endtask
  task automatic end_test(input string t);
    $display("test %s done", t);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] d1;
    logic [31:0] d2;
    logic [31:0] ew;
    logic [3:0] m;
    logic [13:0] col;
    void'($urandom(95481));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    gate_req <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 4; i++) send(CMD_LMR, 2'(i), 14'($urandom));
    for (int i = 0; i < 4; i++) chk_state(mr[i], exp_mr[i]);
    end_test("mode");
    send(CMD_ACT, 2'h0, 14'($urandom));
    send(CMD_ACT, 2'h2, 14'($urandom));
    send(CMD_DESEL, 2'h1, 14'($urandom));
    end_test("bank");
    pd(PWR_ACT_PD);
    send(CMD_PRE, 2'h0, 14'h0000);
    send(CMD_PRE, 2'h1, 14'h0400);
    pd(PWR_PRE_PD);
    end_test("power");
    col = 14'($urandom % 16);
    d1 = $urandom;
    d2 = $urandom;
    m = 4'($urandom);
    send(CMD_ACT, 2'h3, 14'h0001);
    req_wdata <= d1;
    send(CMD_WR, 2'h3, col);
    req_wdata <= d2;
    req_wmask <= m;
    send(CMD_WR, 2'h3, col);
    rd_q.delete();
    send(CMD_RD, 2'h3, col);
    for (int l = 0; l < 4; l++) ew[8*l+:8] = m[l] ? d1[8*l+:8] : d2[8*l+:8];
    chk_word(rd_q.size() > 0 ? rd_q[0] : 32'hx, ew);
    chk_state(14'(rd_q.size()), {10'h0, RD_BEATS});
    end_test("data");
    send(CMD_RD, 2'h3, col | 14'h0400);
    send(CMD_BST, 2'h3, 14'h0000);
    end_test("close");
    print_verdict();
  end
  initial begin
    #50us;
    fail_count++;
    print_verdict();
  end
endmodule

// *** rtl/lp_cmd_ctl.sv ***
// Controller end: holds each command for one cycle around the crossing,
// then drives write beats with mask and a strobe that toggles with each beat, edge-aligned with the data.
module lp_cmd_ctl (
  input wire logic clock,
  input wire logic rst,
  lp_cmd_if.ctl link,
  input wire logic req_valid,
  input wire lp_cmd_pkg::cmd_t req_cmd,
  input wire logic [lp_cmd_pkg::BANK_W-1:0] req_bank,
  input wire logic [lp_cmd_pkg::ADDR_W-1:0] req_addr,
  input wire logic [lp_cmd_pkg::DATA_W-1:0] req_wdata,
  input wire logic [lp_cmd_pkg::LANES-1:0] req_wmask,
  input wire logic req_wlast,
  input wire logic gate_req,
  output logic req_ready,
  output logic [lp_cmd_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid
);
  import lp_cmd_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] a;
    logic wr_on;
    logic [DATA_W-1:0] dq;
    logic [LANES-1:0] dm;
    logic [LANES-1:0] dqs;
    logic oe_n;
    logic ready;
    logic [2:0] wake;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [LANES-1:0] dqs_s1;
    logic [LANES-1:0] dqs_s2;
    logic [LANES-1:0] dqs_prev;
    logic [DATA_W-1:0] rdat;
    logic rvld;
  } ctl_st_t;

  ctl_st_t cur_ff;
  ctl_st_t nxt_st;

  always_comb begin
    nxt_st = cur_ff;
    nxt_st.cke = gate_req;
    nxt_st.cmd = CMD_DESEL;
    nxt_st.oe_n = 1'b1;
    nxt_st.rvld = 1'b0;
    // Hold off requests until the device has seen the clock gate high
    nxt_st.wake = !gate_req ? 3'h0 : (cur_ff.wake == WAKE_CYC) ? WAKE_CYC : cur_ff.wake + 3'h1;
    nxt_st.ready = gate_req && cur_ff.wake == WAKE_CYC && !cur_ff.wr_on;
    // Command held stable for the crossing
    if (req_valid && cur_ff.ready && !cur_ff.wr_on) begin
      nxt_st.cmd = req_cmd;
      nxt_st.ba = req_bank;
      nxt_st.a = req_addr;
      nxt_st.wr_on = (req_cmd == CMD_WR);
      nxt_st.ready = nxt_st.ready && (req_cmd != CMD_WR);
    end else if (cur_ff.wr_on) begin
      // Data and mask change with each strobe edge
      nxt_st.dq = req_wdata;
      nxt_st.dm = req_wmask;
      nxt_st.dqs = ~cur_ff.dqs;
      nxt_st.oe_n = 1'b0;
      if (req_wlast) begin
        nxt_st.wr_on = 1'b0;
      end
    end
    nxt_st.dq_s1 = link.dq_dev;
    nxt_st.dq_s2 = cur_ff.dq_s1;
    nxt_st.dqs_s1 = link.dqs_dev;
    nxt_st.dqs_s2 = cur_ff.dqs_s1;
    nxt_st.dqs_prev = cur_ff.dqs_s2;
    if (|(cur_ff.dqs_s2 ^ cur_ff.dqs_prev)) begin
      nxt_st.rdat = cur_ff.dq_s2;
      nxt_st.rvld = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.cmd <= CMD_DESEL;
      cur_ff.oe_n <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign link.cke = cur_ff.cke;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cur_ff.cmd;
  assign link.array_group_select = cur_ff.ba;
  assign link.addr = cur_ff.a;
  assign link.dq_ctl = cur_ff.dq;
  assign link.byte_write_mask = cur_ff.dm;
  assign link.dqs_ctl = cur_ff.dqs;
  assign link.ctl_oe_n = cur_ff.oe_n;
  assign req_ready = cur_ff.ready;
  assign rd_data = cur_ff.rdat;
  assign rd_valid = cur_ff.rvld;
endmodule

// *** rtl/lp_cmd_dev.sv ***
// Notes on behaviour
// - Address and control registered at clock crossing.
// - Data moves on both clock crossing directions.
// - Clock gate high enables buffers and drivers.
// - Gate low: precharge powerdown, self refresh, active (self refresh is never entered here).
// - Gate synchronous except self refresh exit (exit here uses the synchronised gate too).
// - Powered down: only clock gate buffer live.
// - Chip select low enables command decoder.
// - Chip select high masks every command.
// - Strobes with chip select define the command.
// - Byte with mask high is not written.
// - Masks sampled on both strobe edges.
// - Bank inputs pick target bank of command.
// - Bank inputs pick mode register on load.
// - Precharge: bit ten low one bank, high all.
// - Row on activate, column and auto-close otherwise.
// - Strobe edge-aligned on reads, centred on writes (the controller drives write strobes edge-aligned too).
// Double-rate transfers are modelled as one full data word per system clock,
// the even beat with the first edge and the odd beat with the next.
module lp_cmd_dev (
  input wire logic clock,
  input wire logic rst,
  lp_cmd_if.dev link,
  output logic [lp_cmd_pkg::NBANK-1:0] bank_open,
  output lp_cmd_pkg::pwr_t pwr_state,
  output logic [lp_cmd_pkg::ADDR_W-1:0] mode_reg0,
  output logic [lp_cmd_pkg::ADDR_W-1:0] mode_reg1,
  output logic [lp_cmd_pkg::ADDR_W-1:0] mode_reg2,
  output logic [lp_cmd_pkg::ADDR_W-1:0] mode_reg3,
  output logic cmd_seen
);
  import lp_cmd_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic cke_s1;
    logic cke_s2;
    logic [3:0] cmd_s1;
    logic [3:0] cmd_s2;
    logic [BANK_W-1:0] ba_s1;
    logic [BANK_W-1:0] ba_s2;
    logic [ADDR_W-1:0] a_s1;
    logic [ADDR_W-1:0] a_s2;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [LANES-1:0] dm_s1;
    logic [LANES-1:0] dm_s2;
    logic [LANES-1:0] dqs_s1;
    logic [LANES-1:0] dqs_s2;
    logic [LANES-1:0] dqs_prev;
    pwr_t pwr;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][ADDR_W-1:0] row;
    logic [NBANK-1:0][ADDR_W-1:0] mreg;
    logic wr_act;
    logic [BANK_W-1:0] wr_bank;
    logic [MEM_AW-1:0] wr_col;
    logic [BANK_W-1:0] rd_bank;
    logic [3:0] rd_left;
    logic rd_act;
    logic [1:0] rd_cnt;
    logic [MEM_AW-1:0] rd_col;
    logic [DATA_W-1:0] dq_o;
    logic [LANES-1:0] dqs_o;
    logic oe_n;
    logic seen;
  } dev_st_t;

  dev_st_t cur_ff;
  dev_st_t nxt_st;
  logic [DATA_W-1:0] mem_ff [NBANK*MEM_DEPTH];
  logic mem_we;
  logic [5:0] mem_wa;
  logic [DATA_W-1:0] mem_wd;

  function automatic logic [5:0] mem_idx(input logic [BANK_W-1:0] b,
                                         input logic [MEM_AW-1:0] c);
    mem_idx = {b, c};
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [LANES-1:0] m);
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!m[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic gate_on;
    logic [3:0] code;
    logic [LANES-1:0] dqs_edge;
    logic rd_new;
    nxt_st = cur_ff;
    rd_new = 1'b0;
    gate_on = 1'b0;
    code = 4'h0;
    dqs_edge = 4'h0;
    mem_we = 1'b0;
    mem_wa = 6'h00;
    mem_wd = '0;
    nxt_st.seen = 1'b0;
    // Clock gate pin always sampled, it is the one live buffer
    nxt_st.cke_s1 = link.cke;
    nxt_st.cke_s2 = cur_ff.cke_s1;
    gate_on = cur_ff.cke_s2;
    if (cur_ff.pwr == PWR_SELF_REF) begin
      // Exit seen directly from the second synchronised level, no decode needed
      if (cur_ff.cke_s2) begin
        nxt_st.pwr = PWR_RUN;
      end
    end else if (!gate_on) begin
      if (cur_ff.pwr == PWR_RUN) begin
        nxt_st.pwr = (|cur_ff.open) ? PWR_ACT_PD : PWR_PRE_PD;
      end
    end else if (cur_ff.pwr != PWR_RUN) begin
      nxt_st.pwr = PWR_RUN;
    end
    // Input buffers only follow pins while running
    if (gate_on && cur_ff.pwr == PWR_RUN) begin
      nxt_st.cmd_s1 = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
      nxt_st.ba_s1 = link.array_group_select;
      nxt_st.a_s1 = link.addr;
      nxt_st.dq_s1 = link.dq_ctl;
      nxt_st.dm_s1 = link.byte_write_mask;
      nxt_st.dqs_s1 = link.dqs_ctl;
    end else begin
      nxt_st.cmd_s1 = CMD_DESEL;
    end
    nxt_st.cmd_s2 = cur_ff.cmd_s1;
    nxt_st.ba_s2 = cur_ff.ba_s1;
    nxt_st.a_s2 = cur_ff.a_s1;
    nxt_st.dq_s2 = cur_ff.dq_s1;
    nxt_st.dm_s2 = cur_ff.dm_s1;
    nxt_st.dqs_s2 = cur_ff.dqs_s1;
    nxt_st.dqs_prev = cur_ff.dqs_s2;
    dqs_edge = cur_ff.dqs_s2 ^ cur_ff.dqs_prev;
    // Write data: one beat per strobe edge, either direction
    if (cur_ff.wr_act && |dqs_edge) begin
      mem_we = 1'b1;
      mem_wa = mem_idx(cur_ff.wr_bank, cur_ff.wr_col);
      mem_wd = merge(mem_ff[mem_wa], cur_ff.dq_s2, cur_ff.dm_s2 | ~dqs_edge);
      nxt_st.wr_col = cur_ff.wr_col + 4'h1;
    end
    // Command decode, masked while chip select is high
    code = cur_ff.cmd_s2;
    if (gate_on && cur_ff.pwr == PWR_RUN && !code[3]) begin
      nxt_st.seen = 1'b1;
      case (cmd_t'(code))
        CMD_LMR: nxt_st.mreg[cur_ff.ba_s2] = cur_ff.a_s2;
        CMD_ACT: begin
          nxt_st.open[cur_ff.ba_s2] = 1'b1;
          nxt_st.row[cur_ff.ba_s2] = cur_ff.a_s2;
        end
        CMD_PRE: begin
          if (cur_ff.a_s2[AUTO_CLOSE_POS]) begin
            nxt_st.open = '0;
          end else begin
            nxt_st.open[cur_ff.ba_s2] = 1'b0;
          end
        end
        CMD_WR: begin
          nxt_st.wr_act = cur_ff.open[cur_ff.ba_s2];
          nxt_st.wr_bank = cur_ff.ba_s2;
          nxt_st.wr_col = cur_ff.a_s2[MEM_AW-1:0];
          if (cur_ff.a_s2[AUTO_CLOSE_POS]) begin
            nxt_st.open[cur_ff.ba_s2] = 1'b0;
          end
          nxt_st.rd_act = 1'b0;
        end
        CMD_RD: begin
          nxt_st.rd_act = cur_ff.open[cur_ff.ba_s2];
          nxt_st.rd_cnt = RD_LAT;
          nxt_st.rd_col = cur_ff.a_s2[MEM_AW-1:0];
          nxt_st.rd_bank = cur_ff.ba_s2;
          nxt_st.rd_left = RD_BEATS;
          rd_new = 1'b1;
          nxt_st.wr_act = 1'b0;
          if (cur_ff.a_s2[AUTO_CLOSE_POS]) begin
            nxt_st.open[cur_ff.ba_s2] = 1'b0;
          end
        end
        CMD_BST: begin
          nxt_st.rd_act = 1'b0;
          nxt_st.wr_act = 1'b0;
        end
        default: ;
      endcase
    end
    // Read return: strobe toggles with each beat so its edges align with data
    nxt_st.oe_n = 1'b1;
    if (cur_ff.rd_act && gate_on && !rd_new) begin
      if (cur_ff.rd_cnt != 2'h0) begin
        nxt_st.rd_cnt = cur_ff.rd_cnt - 2'h1;
        nxt_st.oe_n = 1'b0;
        nxt_st.dqs_o = '0;
      end else begin
        nxt_st.oe_n = 1'b0;
        nxt_st.dq_o = mem_ff[mem_idx(cur_ff.rd_bank, cur_ff.rd_col)];
        nxt_st.dqs_o = ~cur_ff.dqs_o;
        nxt_st.rd_col = cur_ff.rd_col + 4'h1;
        nxt_st.rd_left = cur_ff.rd_left - 4'h1;
        // Last beat releases the data bus on the next edge
        if (cur_ff.rd_left == 4'h1) begin
          nxt_st.rd_act = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.cmd_s1 <= CMD_DESEL;
      cur_ff.cmd_s2 <= CMD_DESEL;
      cur_ff.oe_n <= 1'b1;
      cur_ff.pwr <= PWR_RUN;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem_ff[mem_wa] <= mem_wd;
    end
  end

  assign link.dq_dev = cur_ff.dq_o;
  assign link.dqs_dev = cur_ff.dqs_o;
  assign link.dev_oe_n = cur_ff.oe_n;
  assign bank_open = cur_ff.open;
  assign pwr_state = cur_ff.pwr;
  assign mode_reg0 = cur_ff.mreg[0];
  assign mode_reg1 = cur_ff.mreg[1];
  assign mode_reg2 = cur_ff.mreg[2];
  assign mode_reg3 = cur_ff.mreg[3];
  assign cmd_seen = cur_ff.seen;
endmodule

// *** shared/lp_cmd_if.sv ***
interface lp_cmd_if;
  import lp_cmd_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BANK_W-1:0] array_group_select;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_ctl;
  logic [LANES-1:0] byte_write_mask;
  logic [LANES-1:0] dqs_ctl;
  logic ctl_oe_n;
  logic [DATA_W-1:0] dq_dev;
  logic [LANES-1:0] dqs_dev;
  logic dev_oe_n;
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, array_group_select, addr,
    dq_ctl, byte_write_mask, dqs_ctl, ctl_oe_n, input dq_dev, dqs_dev, dev_oe_n);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, array_group_select, addr,
    dq_ctl, byte_write_mask, dqs_ctl, ctl_oe_n, output dq_dev, dqs_dev, dev_oe_n);
endinterface

// *** shared/lp_cmd_pkg.sv ***
package lp_cmd_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int AUTO_CLOSE_POS = 10;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW = 4;
  // ----------------------------------------
  // Command codes {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_LMR = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_BST = 4'h6,
    CMD_NOP = 4'h7,
    CMD_DESEL = 4'h8
  } cmd_t;
  // ----------------------------------------
  // Device power states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_PRE_PD = 2'b01,
    PWR_ACT_PD = 2'b10,
    PWR_SELF_REF = 2'b11
  } pwr_t;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] ALL_LANES = 4'hf;
  localparam logic [1:0] RD_LAT = 2'h2;
  localparam logic [3:0] RD_BEATS = 4'h2;
  localparam logic [2:0] WAKE_CYC = 3'h3;
endpackage
